/* pkg/whfr_pkg.sv */
// Constants, variants and carrier types of the wake handshake and fault retry logic
package whfr_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int OC_DGL0_NS      = 6000;
  localparam int OC_DGL1_NS      = 3000;
  localparam int OC_DGL2_NS      = 1500;
  localparam int OC_DGL3_NS      = 200;
  localparam int RETRY_TIME_MS   = 5;
  localparam int CLEAR_TIME_US   = 100;
  localparam int HOT_CLEAR_MS    = 5;
  localparam int SLEEP_ENTRY_US  = 120;
  localparam int OC_DGL0_CYC     = (OC_DGL0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_DGL1_CYC     = (OC_DGL1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_DGL2_CYC     = (OC_DGL2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_DGL3_CYC     = (OC_DGL3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CYC       = RETRY_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CLEAR_CYC       = CLEAR_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int HOT_CLEAR_CYC   = HOT_CLEAR_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * 1000 / CLK_PERIOD_NS;
  // ==========================================================
  // Widths
  localparam int TMR_W = 17;
  localparam int DGL_W = 7;
  localparam int SLP_W = 12;
  // ==========================================================
  // Interface variants and selects
  localparam logic [1:0] VAR_HW      = 2'h0;
  localparam logic [1:0] VAR_SPI_INT = 2'h1;
  localparam logic [1:0] VAR_SPI_EXT = 2'h2;
  localparam logic [1:0] DGL_SEL_HW  = 2'h0;
  // ==========================================================
  // Registered outputs and sequencer states
  typedef struct packed {
    logic bridge_en;
    logic ind_out;
    logic ind_oe_b;
    logic clamp;
    logic status;
    logic standby;
  } whfr_out_type;
  localparam whfr_out_type OUT_RESET = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  typedef enum logic [2:0] {
    ST_POR, ST_SLEEP, ST_ACK_WAIT, ST_ACTIVE, ST_FAULT_OFF, ST_CLEAR_WAIT
  } whfr_state_type;
endpackage : whfr_pkg

/* hdl/whfr_top.sv */
// Wake handshake, power-on reset hold and fault retry controller of a bridge driver
`timescale 1ns/100ps
module whfr_top
  import whfr_pkg::*;
#(
  parameter int P_RETRY_CYC     = RETRY_CYC,
  parameter int P_HOT_CLEAR_CYC = HOT_CLEAR_CYC
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  // Configuration straps
  input  wire logic [1:0] i_variant,
  input  wire logic       i_retry_mode,
  input  wire logic [1:0] i_overcurrent_deglitch_select,
  // Supply monitors
  input  wire logic       i_ldo_uv,
  input  wire logic       i_vdd_uv,
  // Controller handshake
  input  wire logic       i_sleep_control_pin,
  input  wire logic       i_clear_fault_command,
  input  wire logic       i_drive_enable,
  // Protection comparators
  input  wire logic       i_oc_raw,
  input  wire logic       i_hs_short_gnd,
  input  wire logic       i_thermal_shutdown,
  // Open-drain fault indicator
  input  wire logic       i_fault_indicator_n_in,
  output logic            o_fault_indicator_n_out,
  output logic            o_fault_indicator_n_oe_b,
  // Bridge and status
  output logic            o_bridge_enable,
  output logic            o_current_sense_clamp,
  output logic            o_fault_status,
  output logic            o_standby
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync;
  logic       rst_n;

  // Release through two stages so the release edge is clean
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // Declarations
  whfr_state_type   state;
  whfr_state_type   next_state;
  whfr_out_type     out;
  whfr_out_type     next_out;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic [DGL_W-1:0] oc_cnt;
  logic [DGL_W-1:0] next_oc_cnt;
  logic [SLP_W-1:0] low_cnt;
  logic [SLP_W-1:0] next_low_cnt;
  logic             sleep_q;
  logic             hot_flt;
  logic             next_hot_flt;
  logic [DGL_W-1:0] dgl_lim;
  logic [1:0]       dgl_sel;
  logic             por;
  logic             ext_var;
  logic             rst_pulse;
  logic             go_sleep;
  logic             ack;
  logic             oc_conf;
  logic             hot_hit;
  logic             fault;
  logic             clr_done;

  // ==========================================================
  // Supply, sleep pin and acknowledge decode
  assign ext_var = (i_variant == VAR_SPI_EXT);
  // External-supply variant watches VDD and has no sleep pin
  assign por = ext_var ? i_vdd_uv : i_ldo_uv;
  // A short low pulse on the sleep pin is a reset pulse, a long one is sleep
  assign rst_pulse = !ext_var && i_sleep_control_pin && !sleep_q
                     && (low_cnt < SLP_W'(SLEEP_ENTRY_CYC));
  assign go_sleep = !ext_var && (low_cnt == SLP_W'(SLEEP_ENTRY_CYC));
  // Hardware parts answer the reset pulse, SPI parts the clear command
  assign ack = (i_variant == VAR_HW) ? rst_pulse : i_clear_fault_command;

  // Count how long the sleep pin has stayed low, saturating
  always_comb begin
    next_low_cnt = low_cnt;
    if (i_sleep_control_pin) begin
      next_low_cnt = '0;
    end else if (low_cnt != SLP_W'(SLEEP_ENTRY_CYC)) begin
      next_low_cnt = low_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= '0;
      sleep_q <= 1'b1; // Pin idles high, so reset gives no false rising edge
    end else begin
      low_cnt <= next_low_cnt;
      sleep_q <= i_sleep_control_pin;
    end
  end

  // ==========================================================
  // Overcurrent deglitch
  // Hardware variant has only the slowest choice
  assign dgl_sel = (i_variant == VAR_HW) ? DGL_SEL_HW : i_overcurrent_deglitch_select;

  always_comb begin
    case (dgl_sel)
      2'h0:    dgl_lim = DGL_W'(OC_DGL0_CYC);
      2'h1:    dgl_lim = DGL_W'(OC_DGL1_CYC);
      2'h2:    dgl_lim = DGL_W'(OC_DGL2_CYC);
      default: dgl_lim = DGL_W'(OC_DGL3_CYC);
    endcase
  end

  // Only current seen while the bridge conducts counts toward a fault
  always_comb begin
    next_oc_cnt = '0;
    if (out.bridge_en && i_oc_raw && (oc_cnt < dgl_lim)) begin
      next_oc_cnt = oc_cnt + 1'b1;
    end else if (out.bridge_en && i_oc_raw) begin
      next_oc_cnt = oc_cnt;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oc_cnt <= '0;
    end else begin
      oc_cnt <= next_oc_cnt;
    end
  end

  assign oc_conf = out.bridge_en && i_oc_raw && (oc_cnt == dgl_lim);
  assign hot_hit = out.bridge_en && i_thermal_shutdown;
  assign fault = oc_conf || hot_hit;
  // Auto-clear length depends on which fault caused the shutdown
  assign clr_done = hot_flt ? (tmr == TMR_W'(P_HOT_CLEAR_CYC - 1))
                            : (tmr == TMR_W'(CLEAR_CYC - 1));

  // ==========================================================
  // Sequencer next state
  always_comb begin
    next_state   = state;
    next_out     = out;
    next_tmr     = tmr;
    next_hot_flt = hot_flt;
    next_out.ind_out = 1'b0;
    case (state)
      ST_POR: begin
        next_out = OUT_RESET;
        if (!por) begin
          next_state = ST_ACK_WAIT;
          next_out.ind_oe_b = 1'b0;
        end
      end
      ST_SLEEP: begin
        next_out = OUT_RESET;
        if (i_sleep_control_pin) begin
          next_state = ST_ACK_WAIT;
          next_out.ind_oe_b = 1'b0;
        end
      end
      ST_ACK_WAIT: begin
        if (ack) begin
          next_state = ST_ACTIVE;
          next_out.ind_oe_b = 1'b1;
          next_out.standby = 1'b1;
        end
      end
      ST_ACTIVE: begin
        next_out.bridge_en = i_drive_enable;
        next_out.standby = !i_drive_enable;
      end
      ST_FAULT_OFF: begin
        next_out.bridge_en = 1'b0;
        if (!i_retry_mode) begin
          // Latch reaction waits for the controller
          if (ack) begin
            next_state = ST_ACTIVE;
            next_out.ind_oe_b = 1'b1;
            next_out.clamp = 1'b0;
          end
        end else if (!i_drive_enable) begin
          // Retrying stops while the user keeps the driver disabled
          next_tmr = '0;
        end else if (hot_flt) begin
          if (!i_thermal_shutdown) begin
            next_state = ST_CLEAR_WAIT;
            next_out.bridge_en = 1'b1;
            next_tmr = '0;
          end
        end else if (tmr == TMR_W'(P_RETRY_CYC - 1)) begin
          next_state = ST_CLEAR_WAIT;
          next_out.bridge_en = 1'b1;
          next_out.clamp = 1'b0;
          next_tmr = '0;
        end else begin
          next_tmr = tmr + 1'b1;
        end
      end
      ST_CLEAR_WAIT: begin
        next_out.bridge_en = 1'b1;
        if (clr_done) begin
          next_state = ST_ACTIVE;
          next_out.ind_oe_b = 1'b1;
          next_tmr = '0;
        end else begin
          next_tmr = tmr + 1'b1;
        end
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
    // A confirmed fault overrides the run and auto-clear paths
    if ((state == ST_ACTIVE || state == ST_CLEAR_WAIT) && fault) begin
      next_state = ST_FAULT_OFF;
      next_out.bridge_en = 1'b0;
      next_out.ind_oe_b = 1'b0;
      next_out.standby = 1'b0;
      next_out.clamp = oc_conf && i_hs_short_gnd;
      next_hot_flt = !oc_conf;
      next_tmr = '0;
    end
    // Status is SPI only; a new fault beats a clear in the same cycle
    if (i_clear_fault_command) begin
      next_out.status = 1'b0;
    end
    if (next_state == ST_FAULT_OFF && state != ST_FAULT_OFF && i_variant != VAR_HW) begin
      next_out.status = 1'b1;
    end
    if (go_sleep) begin
      next_state = ST_SLEEP;
      next_out = OUT_RESET;
      next_tmr = '0;
    end
    if (por) begin
      next_state = ST_POR;
      next_out = OUT_RESET;
      next_tmr = '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_POR;
      out     <= OUT_RESET;
      tmr     <= '0;
      hot_flt <= 1'b0;
    end else begin
      state   <= next_state;
      out     <= next_out;
      tmr     <= next_tmr;
      hot_flt <= next_hot_flt;
    end
  end

  // ==========================================================
  // Outputs straight from the registers
  assign o_fault_indicator_n_out  = out.ind_out;
  assign o_fault_indicator_n_oe_b = out.ind_oe_b;
  assign o_bridge_enable          = out.bridge_en;
  assign o_current_sense_clamp    = out.clamp;
  assign o_fault_status           = out.status;
  assign o_standby                = out.standby;

  // ==========================================================
  // Checks
  property p_fault_off;
    @(posedge i_clk_sys) disable iff (!rst_n)
    (state == ST_ACTIVE && fault && !por && !go_sleep)
      |=> (!o_bridge_enable && !o_fault_indicator_n_oe_b);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("Fault did not shut down");

  property p_retry_time;
    @(posedge i_clk_sys) disable iff (!rst_n)
    (state == ST_FAULT_OFF && i_retry_mode && !hot_flt && i_drive_enable
      && tmr == TMR_W'(P_RETRY_CYC - 1) && !por && !go_sleep)
      |=> (state == ST_CLEAR_WAIT && o_bridge_enable);
  endproperty
  a_retry_time: assert property (p_retry_time) else $error("Retry not taken");

  property p_retry_ind_low;
    @(posedge i_clk_sys) disable iff (!rst_n)
    (state == ST_CLEAR_WAIT) |-> !o_fault_indicator_n_oe_b;
  endproperty
  a_retry_ind_low: assert property (p_retry_ind_low) else $error("Indicator freed");

  property p_hot_wait;
    @(posedge i_clk_sys) disable iff (!rst_n)
    (state == ST_FAULT_OFF && hot_flt && i_thermal_shutdown) |=> state != ST_CLEAR_WAIT;
  endproperty
  a_hot_wait: assert property (p_hot_wait) else $error("Retry while hot");

  property p_oc_clear;
    @(posedge i_clk_sys) disable iff (!rst_n)
    (state == ST_CLEAR_WAIT && !hot_flt && tmr == TMR_W'(CLEAR_CYC - 1) && !fault
      && !por && !go_sleep) |=> (o_fault_indicator_n_oe_b && o_bridge_enable);
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("Auto-clear missed");

  property p_status_hold;
    @(posedge i_clk_sys) disable iff (!rst_n)
    (o_fault_status && !i_clear_fault_command && !por && !go_sleep) |=> o_fault_status;
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("Status lost");

  property p_clamp_off;
    @(posedge i_clk_sys) disable iff (!rst_n)
    o_current_sense_clamp |-> !o_bridge_enable;
  endproperty
  a_clamp_off: assert property (p_clamp_off) else $error("Clamp while on");

  property p_ack;
    @(posedge i_clk_sys) disable iff (!rst_n)
    (state == ST_ACK_WAIT && ack && !por && !go_sleep)
      |=> (o_fault_indicator_n_oe_b && o_standby);
  endproperty
  a_ack: assert property (p_ack) else $error("Acknowledge ignored");

  property p_por_hold;
    @(posedge i_clk_sys) disable iff (!rst_n)
    por |=> (state == ST_POR && !o_bridge_enable && o_fault_indicator_n_oe_b);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("Reset not held");

endmodule : whfr_top

/* test/whfr_ctrl_model.sv */
// Behavioural controller on the far side of the wake handshake pins
`timescale 1ns/100ps
module whfr_ctrl_model (
  // Clock
  input  wire logic i_clk_sys,
  // Pins towards the device
  output logic      o_sleep_control_pin,
  output logic      o_clear_fault_command,
  output logic      o_drive_enable
);
  // ==========================================================
  // Pin actions launched 1 ns after a rising edge, except wake, which acts 1 ns after its call
  initial begin
    o_sleep_control_pin   = 1'h1;
    o_clear_fault_command = 1'h0;
    o_drive_enable        = 1'h0;
  end

  // Low pulse far below the sleep entry time, so it reads as an acknowledge
  task automatic reset_pulse();
    @(posedge i_clk_sys) #1 o_sleep_control_pin = 1'h0;
    repeat (10) @(posedge i_clk_sys);
    #1 o_sleep_control_pin = 1'h1;
  endtask : reset_pulse

  // Held low past the sleep entry time so the device really sleeps
  task automatic go_sleep();
    @(posedge i_clk_sys) #1 o_sleep_control_pin = 1'h0;
    repeat (2500) @(posedge i_clk_sys);
    #1;
  endtask : go_sleep

  // Rising sleep pin starts the wake-up
  task automatic wake();
    #1 o_sleep_control_pin = 1'h1;
  endtask : wake

  // One-cycle clear-fault command pulse
  task automatic clear_cmd();
    @(posedge i_clk_sys) #1 o_clear_fault_command = 1'h1;
    @(posedge i_clk_sys) #1 o_clear_fault_command = 1'h0;
  endtask : clear_cmd

  task automatic drive(input logic v);
    @(posedge i_clk_sys) #1 o_drive_enable = v;
  endtask : drive
endmodule : whfr_ctrl_model

/* test/wake_handshake_fault_retry_test.sv */
// Self-checking testbench of the wake handshake and fault retry controller
`timescale 1ns/100ps
module wake_handshake_fault_retry_test;
  import whfr_pkg::*;
  // Shortened retry and thermal clear counts; other expectations use the package counts
  localparam int RETRY = 50;
  localparam int HOT_CLR = 60;
  localparam int BR = 4, IND = 3, CLP = 2, STS = 1, STB = 0;
  logic       clk, rst_b, retry_mode, ldo_uv, vdd_uv, oc, hs, hot;
  logic [1:0] variant, dgl_sel;
  logic       sleep_pin, clr, drive, ind_out, ind_oe_b, bridge, clamp, status, stby;
  int         n_mismatch, checks_done;
  // Open-drain indicator line with its pull-up
  wire        fault_pin = ind_oe_b ? 1'h1 : ind_out;
  wire [4:0]  mon       = {bridge, fault_pin, clamp, status, stby};

  whfr_top #(.P_RETRY_CYC(RETRY), .P_HOT_CLEAR_CYC(HOT_CLR)) i_whfr_top (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_variant(variant), .i_retry_mode(retry_mode),
    .i_overcurrent_deglitch_select(dgl_sel), .i_ldo_uv(ldo_uv), .i_vdd_uv(vdd_uv),
    .i_sleep_control_pin(sleep_pin), .i_clear_fault_command(clr), .i_drive_enable(drive),
    .i_oc_raw(oc), .i_hs_short_gnd(hs), .i_thermal_shutdown(hot),
    .i_fault_indicator_n_in(fault_pin), .o_fault_indicator_n_out(ind_out),
    .o_fault_indicator_n_oe_b(ind_oe_b), .o_bridge_enable(bridge),
    .o_current_sense_clamp(clamp), .o_fault_status(status), .o_standby(stby));

  whfr_ctrl_model i_whfr_ctrl_model (
    .i_clk_sys(clk), .o_sleep_control_pin(sleep_pin),
    .o_clear_fault_command(clr), .o_drive_enable(drive));

  // ==========================================================
  // Shared checking tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Bounded wait for a monitored output, then judged
  task automatic wait_bit(input int b, input logic v, input int max);
    int n = 0;
    while (mon[b] !== v && n < max) begin
      step(1);
      n++;
    end
    check(mon[b], v);
  endtask : wait_bit

  // One missed cycle fails the whole hold
  task automatic hold_bit(input int b, input logic v, input int cyc);
    logic ok = 1'h1;
    repeat (cyc) begin
      step(1);
      if (mon[b] !== v) ok = 1'h0;
    end
    check(ok, 1'h1);
  endtask : hold_bit

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Scenarios
  task automatic t_power_up();
    wait_bit(IND, 1'h0, 10);
    i_whfr_ctrl_model.reset_pulse();
    wait_bit(IND, 1'h1, 4);
    check(mon[STB], 1'h1);
    $display("test power_up done");
  endtask : t_power_up

  // Sleep and wake in the hardware and internal-supply SPI variants, each with its own acknowledge
  task automatic t_wake();
    for (int k = 0; k < 2; k++) begin
      variant = k ? VAR_SPI_INT : VAR_HW;
      i_whfr_ctrl_model.go_sleep();
      check(mon[STB], 1'h0);
      i_whfr_ctrl_model.wake();
      wait_bit(IND, 1'h0, 6);
      if (k) i_whfr_ctrl_model.clear_cmd();
      else i_whfr_ctrl_model.reset_pulse();
      wait_bit(IND, 1'h1, 4);
      check(mon[STB], 1'h1);
    end
    $display("test wake done");
  endtask : t_wake

  // Every deglitch select: output survives until the count, then drops
  task automatic t_deglitch();
    int lim[4] = '{OC_DGL0_CYC, OC_DGL1_CYC, OC_DGL2_CYC, OC_DGL3_CYC};
    retry_mode = 1'h1;
    i_whfr_ctrl_model.drive(1'h1);
    for (int s = 0; s < 4; s++) begin
      dgl_sel = s[1:0];
      wait_bit(BR, 1'h1, RETRY + 10);
      oc = 1'h1;
      // Still on when the count is reached, off on the very next edge
      step(lim[s]);
      check(mon[BR], 1'h1);
      step(1);
      check(mon[BR], 1'h0);
      check(mon[CLP], 1'h0);
      oc = 1'h0;
    end
    wait_bit(IND, 1'h1, 2200);
    $display("test deglitch done");
  endtask : t_deglitch

  task automatic t_oc_retry();
    // Earlier faults left status set; clear it so the next set is visible
    i_whfr_ctrl_model.clear_cmd();
    check(mon[STS], 1'h0);
    hs = 1'h1;
    oc = 1'h1;
    wait_bit(BR, 1'h0, 8);
    check(mon[IND], 1'h0);
    check(mon[STS], 1'h1);
    for (int r = 0; r < 2; r++) begin
      hold_bit(BR, 1'h0, RETRY - 1);
      check(mon[CLP], 1'h1);
      wait_bit(BR, 1'h1, 3);
      check(mon[CLP], 1'h0);
      wait_bit(BR, 1'h0, 8);
      check(mon[IND], 1'h0);
    end
    oc = 1'h0;
    hs = 1'h0;
    wait_bit(BR, 1'h1, RETRY + 10);
    hold_bit(IND, 1'h0, CLEAR_CYC - 1);
    wait_bit(IND, 1'h1, 3);
    check(mon[STS], 1'h1);
    i_whfr_ctrl_model.clear_cmd();
    wait_bit(STS, 1'h0, 3);
    $display("test oc_retry done");
  endtask : t_oc_retry

  // Thermal retry waits for cooling, far beyond the retry interval
  task automatic t_thermal();
    hot = 1'h1;
    wait_bit(BR, 1'h0, 4);
    hold_bit(BR, 1'h0, 4 * RETRY);
    hot = 1'h0;
    wait_bit(BR, 1'h1, 4);
    hold_bit(IND, 1'h0, HOT_CLR - 1);
    wait_bit(IND, 1'h1, 3);
    $display("test thermal done");
  endtask : t_thermal

  task automatic t_latch();
    retry_mode = 1'h0;
    oc = 1'h1;
    wait_bit(BR, 1'h0, 8);
    oc = 1'h0;
    hold_bit(BR, 1'h0, 4 * RETRY);
    i_whfr_ctrl_model.clear_cmd();
    wait_bit(IND, 1'h1, 4);
    wait_bit(BR, 1'h1, 4);
    retry_mode = 1'h1;
    oc = 1'h1;
    wait_bit(BR, 1'h0, 8);
    i_whfr_ctrl_model.drive(1'h0);
    oc = 1'h0;
    hold_bit(BR, 1'h0, 2 * RETRY);
    i_whfr_ctrl_model.drive(1'h1);
    wait_bit(BR, 1'h1, RETRY + 10);
    wait_bit(IND, 1'h1, 2100);
    $display("test latch done");
  endtask : t_latch

  // Undervoltage on the monitored supply of each SPI variant
  task automatic t_por();
    for (int k = 0; k < 2; k++) begin
      variant = k ? VAR_SPI_EXT : VAR_SPI_INT;
      // The supply that this variant does not watch must not reset it
      if (k) ldo_uv = 1'h1;
      else vdd_uv = 1'h1;
      hold_bit(BR, 1'h1, 5);
      {ldo_uv, vdd_uv} = 2'h0;
      if (k) vdd_uv = 1'h1;
      else ldo_uv = 1'h1;
      wait_bit(BR, 1'h0, 4);
      hold_bit(IND, 1'h1, 20);
      ldo_uv = 1'h0;
      vdd_uv = 1'h0;
      wait_bit(IND, 1'h0, 5);
      i_whfr_ctrl_model.clear_cmd();
      wait_bit(IND, 1'h1, 4);
      wait_bit(BR, 1'h1, 4);
    end
    $display("test por done");
  endtask : t_por

  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    {rst_b, retry_mode, ldo_uv, vdd_uv, oc, hs, hot} = 7'h00;
    variant = VAR_HW;
    dgl_sel = DGL_SEL_HW;
    n_mismatch = 0;
    checks_done = 0;
    step(20);
    rst_b = 1'h1;
    t_power_up();
    t_wake();
    t_deglitch();
    t_oc_retry();
    t_thermal();
    t_latch();
    t_por();
    tally_and_finish();
  end

  // Whole run needs about 12500 cycles; this cuts a hang short
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : wake_handshake_fault_retry_test
